// ### hw/trap_interrupt_prioritizer.sv
`default_nettype none
module trap_interrupt_prioritizer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clock_en,
  // sequencer handshake
  input  wire logic        instr_boundary,
  input  wire logic        trap_done,
  // error and trap events, one-cycle pulses
  input  wire logic        control_error_trap,
  input  wire logic        memory_manager,
  input  wire logic        bus_timeout_trap,
  input  wire logic        parity_error_trap,
  input  wire logic        trap_instr,
  input  wire logic        stack_overflow_trap,
  input  wire logic        halt_instr,
  input  wire logic        move_from_status_instr,
  input  wire logic        return_from_trap_instr,
  input  wire logic        return_from_interrupt_instr,
  input  wire logic [7:0]  trap_instr_vector,
  // status word from the datapath
  input  wire logic [15:0] processor_status_word,
  input  wire logic        trace_bit_next,
  // bus pins, asynchronous
  input  wire logic        power_fail_trap,
  input  wire logic        bus_halt_req,
  input  wire logic        irq_level4_line,
  input  wire logic        irq_level5_line,
  input  wire logic        irq_level6_line,
  input  wire logic        irq_level7_line,
  // service request
  output logic             service_valid,
  output logic [3:0]       service_source,
  output logic [7:0]       service_vector,
  output logic [1:0]       service_irq_level,
  output logic             halt_stop,
  output logic             waiting,
  // status byte read
  output logic             status_read_valid,
  output logic [7:0]       status_read_data
);
  //////////////////////////////////////////////////////////////////////
  // helpers

  // mode field of the status word says user
  function automatic logic in_user_mode(input logic [15:0] psw);
    return psw[trap_prio_pkg::mode_lsb +: 2] == trap_prio_pkg::mode_user;
  endfunction

  // highest asserted level line, 0 stands for the lowest level
  function automatic logic [1:0] top_level(input logic [3:0] lines);
    logic [1:0] lvl;
    lvl = 2'h0;
    if (lines[3]) begin
      lvl = 2'h3;
    end else if (lines[2]) begin
      lvl = 2'h2;
    end else if (lines[1]) begin
      lvl = 2'h1;
    end
    return lvl;
  endfunction

  // vector handed out with a source; device and halt carry none here
  function automatic logic [7:0] vector_of(
    input logic [3:0] src,
    input logic [7:0] trap_vec
  );
    logic [7:0] v;
    v = 8'h00;
    case (src)
      trap_prio_pkg::src_control_error:
        v = trap_prio_pkg::vec_control_error;
      trap_prio_pkg::src_memory_manager:
        v = trap_prio_pkg::vec_memory_manager;
      trap_prio_pkg::src_bus_timeout:
        v = trap_prio_pkg::vec_bus_timeout;
      trap_prio_pkg::src_parity:
        v = trap_prio_pkg::vec_parity;
      trap_prio_pkg::src_trap_instr:
        v = trap_vec;
      trap_prio_pkg::src_trace:
        v = trap_prio_pkg::vec_trace;
      trap_prio_pkg::src_stack_ovf:
        v = trap_prio_pkg::vec_stack_ovf;
      trap_prio_pkg::src_power_fail:
        v = trap_prio_pkg::vec_power_fail;
      default:
        v = 8'h00;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // bit 5 power fail, bit 4 bus halt, bits 3..0 level lines 7..4
  wire logic [5:0] pin_raw = {power_fail_trap,
                              bus_halt_req,
                              irq_level7_line,
                              irq_level6_line,
                              irq_level5_line,
                              irq_level4_line};
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       pf_seen;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else if (clock_en) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // power fail is taken once per falling supply, on its rising edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pf_seen <= 1'b0;
    end else if (clock_en) begin
      pf_seen <= pin_sync[5];
    end
  end

  wire logic pf_rise = pin_sync[5] & ~pf_seen;

  //////////////////////////////////////////////////////////////////////
  // instruction events

  wire logic user_now     = in_user_mode(processor_status_word);
  wire logic halt_trap_ev = halt_instr & user_now;
  wire logic halt_stop_ev = halt_instr & ~user_now;
  // trace is latched here, so a following return that clears it is moot
  wire logic trace_ev     = return_from_trap_instr & trace_bit_next;

  //////////////////////////////////////////////////////////////////////
  // pending sources

  trap_prio_pkg::state_e state;
  trap_prio_pkg::state_e next_state;
  logic [7:0]  trap_pend;
  logic [7:0]  trap_vec;
  logic        enc_any;
  logic [3:0]  enc_index;
  logic [2:0]  settle_cnt;

  wire logic [7:0] pend_set = {pf_rise,
                               stack_overflow_trap,
                               trace_ev,
                               trap_instr | halt_trap_ev,
                               parity_error_trap,
                               bus_timeout_trap,
                               memory_manager,
                               control_error_trap};

  wire logic svc_finish = (state == trap_prio_pkg::st_service) & trap_done;
  wire logic [10:0] svc_onehot = 11'h001 << service_source;
  wire logic [7:0]  pend_clear = svc_finish ? svc_onehot[7:0] : 8'h00;
  // a new event in the clearing cycle keeps its flag
  wire logic [7:0]  next_trap_pend = (trap_pend & ~pend_clear) | pend_set;

  wire logic [7:0] next_trap_vec =
    trap_instr   ? trap_instr_vector :
    halt_trap_ev ? trap_prio_pkg::vec_reserved : trap_vec;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trap_pend <= 8'h00;
      trap_vec  <= 8'h00;
    end else if (clock_en) begin
      trap_pend <= next_trap_pend;
      trap_vec  <= next_trap_vec;
    end
  end

  // bit order is service order, lowest bit first; wait loop is last
  wire logic [10:0] pending_all = {~halt_stop,
                                   pin_sync[4],
                                   |pin_sync[3:0],
                                   trap_pend};

  pri_encoder #(
    .width (trap_prio_pkg::n_src)
  ) u_enc (
    .clock   (clock),
    .rstn    (rstn),
    .enable  (clock_en),
    .pending (pending_all),
    .any     (enc_any),
    .index   (enc_index)
  );

  //////////////////////////////////////////////////////////////////////
  // service sequencer

  wire logic enc_is_wait = enc_index == trap_prio_pkg::src_wait_loop;
  wire logic in_idle     = state == trap_prio_pkg::st_idle;
  wire logic pick_ready  = in_idle & instr_boundary & enc_any & ~halt_stop &
                           ~enc_is_wait;
  wire logic settle_done =
    settle_cnt == 3'(trap_prio_pkg::irq_settle - 1);
  // gives the encoder and the level lines time to show the cleared source
  wire logic [2:0] next_settle =
    (state == trap_prio_pkg::st_ack && !settle_done) ?
    settle_cnt + 3'h1 : 3'h0;
  wire logic [7:0] next_vector  = vector_of(enc_index, trap_vec);
  wire logic [1:0] next_level   = top_level(pin_sync[3:0]);
  wire logic       next_waiting = in_idle & enc_any & enc_is_wait &
                                  ~halt_stop;

  always_comb begin
    next_state = state;
    case (state)
      trap_prio_pkg::st_idle:
        if (pick_ready) next_state = trap_prio_pkg::st_service;
      trap_prio_pkg::st_service:
        if (trap_done) next_state = trap_prio_pkg::st_ack;
      trap_prio_pkg::st_ack:
        if (settle_done) next_state = trap_prio_pkg::st_idle;
      default:
        next_state = trap_prio_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state      <= trap_prio_pkg::st_idle;
      settle_cnt <= 3'h0;
    end else if (clock_en) begin
      state      <= next_state;
      settle_cnt <= next_settle;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      service_valid     <= 1'b0;
      service_source    <= 4'h0;
      service_vector    <= 8'h00;
      service_irq_level <= 2'h0;
    end else if (clock_en) begin
      if (pick_ready) begin
        service_valid     <= 1'b1;
        service_source    <= enc_index;
        service_vector    <= next_vector;
        service_irq_level <= next_level;
      end else if (svc_finish) begin
        service_valid     <= 1'b0;
      end
    end
  end

  // a kernel halt stops all service until reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      halt_stop <= 1'b0;
      waiting   <= 1'b0;
    end else if (clock_en) begin
      halt_stop <= halt_stop | halt_stop_ev;
      waiting   <= next_waiting;
    end
  end

  // status byte read never touches the trap path
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_read_valid <= 1'b0;
      status_read_data  <= 8'h00;
    end else if (clock_en) begin
      status_read_valid <= move_from_status_instr;
      if (move_from_status_instr) begin
        status_read_data <= processor_status_word[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/trap_prio_pkg.sv
`default_nettype none
package trap_prio_pkg;
  // trap vectors, written in octal
  localparam logic [7:0] vec_control_error = 8'o004;
  localparam logic [7:0] vec_memory_manager = 8'o250;
  localparam logic [7:0] vec_bus_timeout   = 8'o004;
  localparam logic [7:0] vec_parity        = 8'o114;
  localparam logic [7:0] vec_reserved      = 8'o010;
  localparam logic [7:0] vec_trace         = 8'o014;
  localparam logic [7:0] vec_stack_ovf     = 8'o004;
  localparam logic [7:0] vec_power_fail    = 8'o024;
  localparam logic [15:0] status_word_addr = 16'hFFFE; // 177776 octal
  localparam int unsigned n_src   = 11;
  localparam int unsigned pri_lsb = 5;
  localparam int unsigned mode_lsb = 14;
  localparam logic [1:0] mode_user = 2'b11;
  // cycles spent after a service before pending sources are weighed again
  localparam int unsigned irq_settle = 4;

  typedef enum logic [3:0] {
    src_control_error  = 4'h0,
    src_memory_manager = 4'h1,
    src_bus_timeout    = 4'h2,
    src_parity         = 4'h3,
    src_trap_instr     = 4'h4,
    src_trace          = 4'h5,
    src_stack_ovf      = 4'h6,
    src_power_fail     = 4'h7,
    src_device_irq     = 4'h8,
    src_bus_halt       = 4'h9,
    src_wait_loop      = 4'hA
  } src_e;

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_service = 2'b01,
    st_ack     = 2'b10
  } state_e;
endpackage
`default_nettype wire

// ### hw/pri_encoder.sv
`default_nettype none
// picks the lowest numbered pending source, registered
module pri_encoder #(
  parameter int unsigned width = 11
) (
  // clock
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             enable,
  // request vector
  input  wire logic [width-1:0] pending,
  // result
  output logic                  any,
  output logic [3:0]            index
);
  function automatic logic [3:0] first_set(input logic [width-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = width - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  wire logic [3:0] next_index = first_set(pending);
  wire logic       next_any   = |pending;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      any   <= 1'b0;
      index <= 4'h0;
    end else if (enable) begin
      any   <= next_any;
      index <= next_index;
    end
  end
endmodule
`default_nettype wire

// ### test/irq_dev.sv
`default_nettype none
module irq_dev(input wire logic clock,req,ack,output logic line);
  timeunit 1ns; timeprecision 1ns;
  initial line=0;
  // holds its level line until serviced
  always @(posedge clock) line<=ack?0:(req|line);
endmodule
`default_nettype wire

// ### test/tp_chk.sv
`default_nettype none
module tp_chk(input wire logic clock,rstn,halt_instr,halt_stop,
  input wire logic return_from_trap_instr,return_from_interrupt_instr,
  input wire logic trace_bit_next,service_valid,status_read_valid,
  input wire logic trap_done,clock_en,move_from_status_instr,waiting,
  input wire logic [15:0] processor_status_word,
  input wire logic [3:0] service_source,
  input wire logic [7:0] service_vector,status_read_data);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire usr=processor_status_word[15:14]==2'h3;
  halt_user_a: assert property(halt_instr&&usr|->##[1:60]
    service_valid&&service_vector==8'h08&&!halt_stop) else $error("halt");
  status_byte_a: assert property(status_read_valid|->
    status_read_data==processor_status_word[7:0]) else $error("status");
  trace_kept_a: assert property(return_from_trap_instr&&trace_bit_next
    ##1 return_from_interrupt_instr|->##[1:60] service_valid&&
    service_source==4'h5) else $error("trace");
  svc_hold_a: assert property(service_valid&&!trap_done|=>
    service_valid&&$stable(service_source)) else $error("hold");
  svc_drop_a: assert property(service_valid&&trap_done&&clock_en|=>
    !service_valid) else $error("drop");
  status_now_a: assert property(move_from_status_instr&&clock_en|=>
    status_read_valid) else $error("status late");
  halt_kernel_a: assert property(halt_instr&&!usr&&clock_en|=>
    halt_stop) else $error("kernel halt");
  wait_idle_a: assert property(waiting|->!service_valid) else $error("wait");
  cover property(halt_instr&&usr);
  cover property(status_read_valid);
  cover property(service_valid&&service_source==4'h8);
endmodule
bind trap_interrupt_prioritizer tp_chk c(.*);
`default_nettype wire

// ### test/tb.sv
`default_nettype none
module tb;
  timeunit 1ns; timeprecision 1ns;
  logic clock=0,rstn=0,clock_en=1,instr_boundary=1,trap_done=0,
    control_error_trap=0,memory_manager=0,bus_timeout_trap=0,
    parity_error_trap=0,trap_instr=0,stack_overflow_trap=0,halt_instr=0,
    move_from_status_instr=0,return_from_trap_instr=0,trace_bit_next=0,
    return_from_interrupt_instr=0,power_fail_trap=0,bus_halt_req=0,
    irq_level4_line,irq_level5_line,irq_level6_line,irq_level7_line,
    service_valid,halt_stop,waiting,status_read_valid;
  logic [7:0] trap_instr_vector=8'h20,service_vector,status_read_data;
  logic [15:0] processor_status_word=16'hC000;
  logic [3:0] service_source;
  logic [1:0] service_irq_level;
  logic [7:0] vt[7]='{8'h04,8'hA8,8'h04,8'h4C,8'h20,8'h0C,8'h04};
  int n_fail=0,check_count=0,seed=26,cyc=0,i,b;
  logic [6:0] p;
  logic [3:0] rq=0,q;
  trap_interrupt_prioritizer dut(.*);
  irq_dev p4(.clock,.req(rq[0]),.ack(service_valid&&service_source==4'h8&&
    service_irq_level==2'h0),.line(irq_level4_line));
  irq_dev p5(.clock,.req(rq[1]),.ack(service_valid&&service_source==4'h8&&
    service_irq_level==2'h1),.line(irq_level5_line));
  irq_dev p6(.clock,.req(rq[2]),.ack(service_valid&&service_source==4'h8&&
    service_irq_level==2'h2),.line(irq_level6_line));
  irq_dev p7(.clock,.req(rq[3]),.ack(service_valid&&service_source==4'h8&&
    service_irq_level==2'h3),.line(irq_level7_line));
  initial forever #10 clock=~clock;
  always @(posedge clock) if(++cyc>5000) begin n_fail++; conclude; end
  task cmp(input logic [7:0] g,e);
    check_count++;
    if(g!==e) begin n_fail++; $display("BAD %0t got %h",$time,g); end
  endtask
  task chk(input logic [3:0] s,input logic [7:0] v,input logic [1:0] l);
    for(i=0;i<60&&service_valid!==1;i++) @(negedge clock);
    cmp({4'h0,service_source},{4'h0,s});
    if(s!=8) cmp(service_vector,v);
    else cmp({6'h0,service_irq_level},{6'h0,l});
    trap_done=1; @(negedge clock); trap_done=0;
  endtask
  task conclude;
    $display("fails %0d checks %0d",n_fail,check_count);
    if(n_fail==0&&check_count>0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat(8) @(negedge clock); rstn=1;
    repeat(12) begin
      @(negedge clock) p=$random(seed); p[5]=0;
      {stack_overflow_trap,trap_instr,parity_error_trap,bus_timeout_trap,
        memory_manager,control_error_trap}={p[6],p[4:0]};
      @(negedge clock) {stack_overflow_trap,trap_instr,parity_error_trap,
        bus_timeout_trap,memory_manager,control_error_trap}=0;
      while(p) begin b=0; while(!p[b]) b++; chk(b,vt[b],0); p[b]=0; end
    end
    halt_instr=1; @(negedge clock) halt_instr=0; chk(4,8'h08,0);
    {return_from_trap_instr,trace_bit_next}=3; @(negedge clock);
    {return_from_trap_instr,trace_bit_next,return_from_interrupt_instr}=1;
    @(negedge clock) return_from_interrupt_instr=0; chk(5,8'h0C,0);
    q=$random(seed); q[3]=1; rq=q; @(negedge clock) rq=0;
    for(b=3;b>=0;b--) if(q[b]) chk(8,0,b);
    power_fail_trap=1; chk(7,8'h14,0); power_fail_trap=0;
    bus_halt_req=1;
    for(i=0;i<60&&service_valid!==1;i++) @(negedge clock);
    bus_halt_req=0; chk(9,0,0);
    processor_status_word[7:0]=$random(seed); move_from_status_instr=1;
    @(negedge clock) move_from_status_instr=0;
    for(i=0;i<9&&status_read_valid!==1;i++) @(negedge clock);
    cmp(status_read_data,processor_status_word[7:0]);
    cmp({7'h0,service_valid},8'h00);
    repeat(10) @(negedge clock);
    cmp({7'h0,waiting},8'h01);
    processor_status_word=16'h0000; halt_instr=1;
    @(negedge clock) halt_instr=0; @(negedge clock);
    cmp({7'h0,halt_stop},8'h01);
    conclude;
  end
endmodule
`default_nettype wire
